// ===== shared/ubf_pkg.sv
// Constants and types of the serial transceiver buffer and flag block
// Assumes one 100 MHz clock and an APB register bus
package ubf_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_BAUD = 12'h00C;
  // status_ctrl_a bit positions
  localparam int unsigned SA_RXC = 0;
  localparam int unsigned SA_TXC = 1;
  localparam int unsigned SA_TX_BUFFER_EMPTY_FLAG = 2;
  localparam int unsigned SA_FE = 3;
  localparam int unsigned SA_OVR = 4;
  localparam int unsigned SA_PE = 5;
  // status_ctrl_b read-only rx_ninth_bit position
  localparam int unsigned CB_RX9 = 13;
  localparam logic [15:0] BAUD_RST = 16'h0363;
  // ************************************************************
  // Types
  // ************************************************************
  // status_ctrl_b, bit 12 down to bit 0
  typedef struct packed {
    logic sync_mode;
    logic two_stop;
    logic parity_odd;
    logic parity_enable;
    logic [2:0] char_size_select;
    logic tx_ninth_bit;
    logic transmitter_on;
    logic receiver_on;
    logic tx_empty_irq_enable;
    logic tx_done_irq_enable;
    logic rx_complete_irq_enable;
  } ubf_ctrl_s;
  localparam int unsigned CTRL_W = $bits(ubf_ctrl_s);
  localparam ubf_ctrl_s CTRL_RST = 13'h0000;
  typedef struct packed {
    logic fe;
    logic ovr;
    logic pe;
    logic [8:0] data;
  } ubf_rxent_s;
  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_SEND = 2'h1} ubf_tx_e;
  typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_START = 2'h1, RX_BITS = 2'h3} ubf_rx_e;
endpackage

// ===== hw/ubf_core.sv
// Transmit and receive buffering, flags and interrupt requests of a UART
// Assumes APB master on clk, serial pins already synchronous to clk
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
module ubf_core
  import ubf_pkg::*;
#(
  parameter int unsigned RX_DEPTH = 2
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic rx_pin_claim,
  input wire logic ext_sync_clock,
  input wire logic global_irq_enable,
  input wire logic tx_done_irq_ack,
  output logic irq_tx_empty,
  output logic irq_tx_done,
  output logic irq_rx_complete
);
  localparam int unsigned PW = $clog2(RX_DEPTH);

  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0)
  begin : g_chk
    $error("RX_DEPTH must be a power of two, at least 2");
  end

  // ************************************************************
  // Frame format helpers
  // ************************************************************
  function automatic logic [3:0] char_bits(input logic [2:0] size);
    case (size)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      3'h7: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  function automatic logic [8:0] char_mask(input logic [3:0] n);
    char_mask = 9'h1FF >> (4'h9 - n);
  endfunction

  function automatic logic [10:0] tx_frame(input logic [8:0] d, input logic [3:0] n,
    input logic pen, input logic odd);
    logic [8:0] m;
    m = d & char_mask(n);
    tx_frame = {2'h3, m} | (11'h7FF << n);
    if (pen)
    begin
      tx_frame[n] = ^m ^ odd;
    end
  endfunction

  // ************************************************************
  // APB slave
  // ************************************************************
  ubf_ctrl_s ctrl_ff;
  logic [15:0] baud_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rd_word;
  ubf_rxent_s mem [RX_DEPTH];
  logic [PW-1:0] rp_ff;
  logic [PW-1:0] wp_ff;
  logic [PW:0] cnt_ff;
  logic tx_buf_v_ff;
  logic txc_ff;

  wire logic setup = psel && !penable;
  wire logic acc = psel && penable;
  wire logic hit_data = paddr == OFS_DATA;
  wire logic hit_stat = paddr == OFS_STAT;
  wire logic hit_ctrl = paddr == OFS_CTRL;
  wire logic hit_baud = paddr == OFS_BAUD;
  wire logic mapped = hit_data || hit_stat || hit_ctrl || hit_baud;
  wire logic wr_data = acc && pwrite && hit_data;
  wire logic wr_stat = acc && pwrite && hit_stat;
  wire logic wr_ctrl = acc && pwrite && hit_ctrl;
  wire logic wr_baud = acc && pwrite && hit_baud;
  wire logic rd_data = acc && !pwrite && hit_data;
  wire logic [3:0] nb = char_bits(ctrl_ff.char_size_select);
  wire logic [8:0] dmask = char_mask(nb);
  wire logic rx_complete_flag = cnt_ff != '0;
  wire logic tx_buffer_empty_flag = !tx_buf_v_ff;
  wire ubf_rxent_s head = mem[rp_ff];

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_ff;

  // Status and ninth bit show the FIFO head only while it holds data
  always_comb
  begin
    rd_word = '0;
    if (hit_data)
    begin
      rd_word[7:0] = head.data[7:0] & dmask[7:0] & {8{rx_complete_flag}};
    end
    if (hit_stat)
    begin
      rd_word[SA_RXC] = rx_complete_flag;
      rd_word[SA_TXC] = txc_ff;
      rd_word[SA_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag;
      rd_word[SA_FE] = head.fe && rx_complete_flag;
      rd_word[SA_OVR] = head.ovr && rx_complete_flag;
      rd_word[SA_PE] = head.pe && rx_complete_flag;
    end
    if (hit_ctrl)
    begin
      rd_word[CTRL_W-1:0] = ctrl_ff;
      rd_word[CB_RX9] = head.data[8] && rx_complete_flag;
    end
    if (hit_baud)
    begin
      rd_word[15:0] = baud_ff;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prdata_ff <= '0;
      ctrl_ff <= CTRL_RST;
      baud_ff <= BAUD_RST;
    end
    else
    begin
      if (setup && !pwrite)
        prdata_ff <= rd_word;
      if (wr_ctrl)
        ctrl_ff <= ubf_ctrl_s'(pwdata[CTRL_W-1:0]);
      if (wr_baud)
        baud_ff <= pwdata[15:0];
    end
  end

  // ************************************************************
  // Transmitter
  // ************************************************************
  ubf_tx_e tx_st_ff;
  logic [8:0] tx_buf_ff;
  logic tx_on_ff;
  logic [10:0] tx_sh_ff;
  logic [3:0] tx_left_ff;
  logic [15:0] tx_bcnt_ff;
  logic sout_ff;
  logic ext_q_ff;

  wire logic ext_rise = ext_sync_clock && !ext_q_ff;
  wire logic ext_fall = !ext_sync_clock && ext_q_ff;
  wire logic tx_tick = ctrl_ff.sync_mode ? ext_fall : (tx_bcnt_ff == '0);
  wire logic tx_shift = tx_st_ff == TX_SEND && tx_tick;
  wire logic tx_last = tx_shift && tx_left_ff == 4'h1;
  wire logic tx_idle_go = tx_st_ff == TX_IDLE && (!ctrl_ff.sync_mode || ext_fall);
  wire logic tx_load = tx_on_ff && tx_buf_v_ff && (tx_idle_go || tx_last);
  wire logic [3:0] tx_len = nb + {3'h0, ctrl_ff.parity_enable}
    + {3'h0, ctrl_ff.two_stop} + 4'h2;
  wire logic txc_clr = tx_done_irq_ack || (wr_stat && pwdata[SA_TXC]);

  assign serial_out_pin = sout_ff;
  assign serial_out_oe = tx_on_ff;
  assign irq_tx_empty = global_irq_enable && ctrl_ff.tx_empty_irq_enable && tx_buffer_empty_flag;
  assign irq_tx_done = global_irq_enable && ctrl_ff.tx_done_irq_enable && txc_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_buf_v_ff <= 1'b0;
      tx_buf_ff <= '0;
      txc_ff <= 1'b0;
      tx_on_ff <= 1'b0;
      ext_q_ff <= 1'b0;
    end
    else
    begin
      ext_q_ff <= ext_sync_clock;
      if (wr_data)
        tx_buf_ff <= {ctrl_ff.tx_ninth_bit, pwdata[7:0]};
      tx_buf_v_ff <= wr_data || (tx_buf_v_ff && !tx_load);
      txc_ff <= (tx_last && !tx_buf_v_ff) || (txc_ff && !txc_clr);
      if (ctrl_ff.transmitter_on)
        tx_on_ff <= 1'b1;
      else if (!tx_buf_v_ff && tx_st_ff == TX_IDLE)
        tx_on_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_st_ff <= TX_IDLE;
      tx_sh_ff <= '1;
      tx_left_ff <= '0;
      tx_bcnt_ff <= '0;
      sout_ff <= 1'b1;
    end
    else
    begin
      tx_bcnt_ff <= (tx_load || tx_bcnt_ff == '0) ? baud_ff : tx_bcnt_ff - 16'h0001;
      if (tx_load)
      begin
        tx_st_ff <= TX_SEND;
        tx_left_ff <= tx_len;
        tx_sh_ff <= tx_frame(tx_buf_ff, nb, ctrl_ff.parity_enable,
          ctrl_ff.parity_odd);
        sout_ff <= 1'b0;
      end
      else if (tx_shift)
      begin
        tx_st_ff <= tx_last ? TX_IDLE : TX_SEND;
        tx_left_ff <= tx_left_ff - 4'h1;
        tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
        sout_ff <= tx_sh_ff[0];
      end
    end
  end

  // ************************************************************
  // Receiver
  // ************************************************************
  ubf_rx_e rx_st_ff;
  logic [15:0] rx_cnt_ff;
  logic [3:0] rx_idx_ff;
  logic [8:0] rx_sh_ff;
  logic rx_par_ff;
  ubf_rxent_s hold_ff;
  logic hold_v_ff;
  logic ovr_pend_ff;

  wire logic rx_on = ctrl_ff.receiver_on;
  wire logic rx_in = serial_in_pin || !rx_on;
  wire logic rx_tick = ctrl_ff.sync_mode ? ext_rise : (rx_cnt_ff == '0);
  wire logic start_ok = ctrl_ff.sync_mode
    ? (rx_st_ff == RX_IDLE && ext_rise && !rx_in)
    : (rx_st_ff == RX_START && rx_tick && !rx_in);
  wire logic samp = rx_st_ff == RX_BITS && rx_tick;
  wire logic rx_done = samp && rx_idx_ff == nb + {3'h0, ctrl_ff.parity_enable};
  wire logic full = cnt_ff == (PW+1)'(RX_DEPTH);
  wire logic pop = rd_data && rx_complete_flag;
  wire logic push_hold = hold_v_ff && !full;
  wire logic push_new = rx_done && !hold_v_ff && !full;
  wire logic push = push_hold || push_new;
  wire logic hold_load = rx_done && (hold_v_ff ? push_hold : full);
  wire logic rx_pe = ctrl_ff.parity_enable && (^rx_sh_ff ^ ctrl_ff.parity_odd ^ rx_par_ff);
  wire ubf_rxent_s new_ent = '{fe: !rx_in, ovr: 1'b0, pe: rx_pe, data: rx_sh_ff};
  wire ubf_rxent_s src_ent = push_hold ? hold_ff : new_ent;
  wire ubf_rxent_s push_ent = '{fe: src_ent.fe, ovr: ovr_pend_ff, pe: src_ent.pe,
    data: src_ent.data};

  assign rx_pin_claim = rx_on;
  assign irq_rx_complete = global_irq_enable && ctrl_ff.rx_complete_irq_enable && rx_complete_flag;

  always_ff @(posedge clk)
  begin
    if (sys_rst || !rx_on)
    begin
      rx_st_ff <= RX_IDLE;
      rx_idx_ff <= '0;
      rx_sh_ff <= '0;
      rx_par_ff <= 1'b0;
    end
    else
    begin
      if (start_ok)
      begin
        rx_st_ff <= RX_BITS;
        rx_idx_ff <= '0;
        rx_sh_ff <= '0;
      end
      else if (rx_done)
        rx_st_ff <= RX_IDLE;
      else if (samp)
      begin
        rx_idx_ff <= rx_idx_ff + 4'h1;
        if (rx_idx_ff < nb)
          rx_sh_ff[rx_idx_ff] <= rx_in;
        else
          rx_par_ff <= rx_in;
      end
      else if (rx_st_ff == RX_IDLE && !rx_in && !ctrl_ff.sync_mode)
        rx_st_ff <= RX_START;
      else if (rx_st_ff == RX_START && rx_tick)
        rx_st_ff <= RX_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rx_cnt_ff <= '0;
    else if (rx_st_ff == RX_IDLE)
      rx_cnt_ff <= baud_ff >> 1;
    else
      rx_cnt_ff <= (rx_cnt_ff == '0) ? baud_ff : rx_cnt_ff - 16'h0001;
  end

  // Held frame waits in hold_ff while the FIFO is full
  always_ff @(posedge clk)
  begin
    if (sys_rst || !rx_on)
    begin
      hold_v_ff <= 1'b0;
      hold_ff <= '0;
      ovr_pend_ff <= 1'b0;
      cnt_ff <= '0;
      rp_ff <= '0;
      wp_ff <= '0;
    end
    else
    begin
      if (hold_load)
        hold_ff <= new_ent;
      hold_v_ff <= hold_load || (hold_v_ff && !push_hold);
      ovr_pend_ff <= (start_ok && full && hold_v_ff) || (ovr_pend_ff && !push_hold);
      cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
      rp_ff <= rp_ff + PW'(pop);
      wp_ff <= wp_ff + PW'(push);
    end
  end

  for (genvar gi = 0; gi < RX_DEPTH; gi++)
  begin : g_mem
    always_ff @(posedge clk)
    begin
      if (push && wp_ff == PW'(gi))
        mem[gi] <= push_ent;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_tx_buffer_empty_flag_clr;
    wr_data |=> !tx_buffer_empty_flag && tx_buf_ff == $past({ctrl_ff.tx_ninth_bit, pwdata[7:0]});
  endproperty
  a_tx_buffer_empty_flag_clr: assert property (p_tx_buffer_empty_flag_clr) else $error("data write left empty flag set");

  property p_tx_buffer_empty_flag_set;
    (tx_load && !wr_data) |=> tx_buffer_empty_flag && tx_st_ff == TX_SEND;
  endproperty
  a_tx_buffer_empty_flag_set: assert property (p_tx_buffer_empty_flag_set) else $error("empty flag not set on move");

  property p_move;
    (tx_on_ff && tx_buf_v_ff && tx_st_ff == TX_IDLE && !ctrl_ff.sync_mode)
      |=> tx_st_ff == TX_SEND && !serial_out_pin;
  endproperty
  a_move: assert property (p_move) else $error("idle shifter did not take buffer");

  property p_txc_set;
    (tx_last && !tx_buf_v_ff) |=> txc_ff && irq_tx_done == (global_irq_enable
      && ctrl_ff.tx_done_irq_enable);
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("done flag not set after frame");

  property p_txc_clr;
    (txc_clr && !tx_last) |=> !txc_ff;
  endproperty
  a_txc_clr: assert property (p_txc_clr) else $error("done flag not cleared");

  property p_tx_hold;
    (!ctrl_ff.transmitter_on && tx_on_ff && (tx_buf_v_ff || tx_st_ff == TX_SEND))
      |=> serial_out_oe;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("pin released mid transfer");

  property p_rxc;
    (push && !pop) |=> rx_complete_flag && $changed(cnt_ff);
  endproperty
  a_rxc: assert property (p_rxc) else $error("receive flag low after push");

  property p_flush;
    !rx_on |=> !rx_complete_flag && !irq_rx_complete;
  endproperty
  a_flush: assert property (p_flush) else $error("receiver off left data");

  property p_mask;
    (setup && !pwrite && hit_data && ctrl_ff.char_size_select < 3'h3) |=> !prdata[7];
  endproperty
  a_mask: assert property (p_mask) else $error("unused data bit not zero");

  property p_ovr;
    (start_ok && full && hold_v_ff) |=> ovr_pend_ff;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not recorded");

  c_back2back: cover property (tx_last && tx_load);
  c_overrun: cover property (start_ok && full && hold_v_ff);
  c_flush: cover property ($fell(rx_on) && rx_complete_flag);
  c_frame_err: cover property (push_new && new_ent.fe);
endmodule

// ===== testbench/ubf_peer.sv
// Remote serial peer: sends frames on the receive line, decodes the transmit line
// Assumes even parity, format set by the bench through nbits and par_en
`timescale 1ns/100ps
module ubf_peer #(
  parameter int BIT_T = 4
)(
  input wire logic clk,
  input wire logic serial_out_pin,
  output logic serial_in_pin,
  output logic ext_sync_clock
);
  int nbits = 8;
  int par_en = 1;
  int got_q[$];
  initial
  begin
    serial_in_pin = 1'b1;
    ext_sync_clock = 1'b0;
  end
  // ****************
  // Frame sender
  // ****************
  task automatic send(input int d, input int bad_par, input int bad_stop, input int sync);
    int bits[$];
    int p;
    p = bad_par;
    bits.push_back(0);
    for (int i = 0; i < nbits; i++)
    begin
      bits.push_back((d >> i) & 1);
      p ^= (d >> i) & 1;
    end
    if (par_en != 0)
      bits.push_back(p);
    bits.push_back(bad_stop == 0);
    foreach (bits[i])
      if (sync != 0)
      begin
        @(posedge clk) serial_in_pin <= bits[i][0];
        repeat (BIT_T / 2) @(posedge clk);
        ext_sync_clock <= 1'b1;
        repeat (BIT_T / 2) @(posedge clk);
        ext_sync_clock <= 1'b0;
      end
      else
        repeat (BIT_T) @(posedge clk) serial_in_pin <= bits[i][0];
    repeat (BIT_T) @(posedge clk) serial_in_pin <= 1'b1;
  endtask
  // Data, parity and stop sampled mid-bit, packed LSB first
  always
  begin
    int v;
    @(negedge serial_out_pin);
    repeat (BIT_T / 2) @(posedge clk);
    v = 0;
    for (int i = 0; i <= nbits + par_en; i++)
    begin
      repeat (BIT_T) @(posedge clk);
      v |= int'(serial_out_pin) << i;
    end
    got_q.push_back(v);
  end
endmodule

// ===== testbench/tb_ubf_core.sv
// Self-checking bench of the buffer and flag block
// Assumes the peer model and a bit time of four clock cycles
`timescale 1ns/100ps
module tb_ubf_core;
  import ubf_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic serial_in_pin;
  logic serial_out_pin;
  logic serial_out_oe;
  logic rx_pin_claim;
  logic ext_sync_clock;
  logic gie = 1'b0;
  logic txc_ack = 1'b0;
  logic irq_tx_empty;
  logic irq_tx_done;
  logic irq_rx_complete;
  logic [31:0] rd;
  logic [31:0] st;
  logic perr;
  int n_errors = 0;
  int n_compared = 0;
  int seed = 7698;
  int cyc = 0;
  int exp_q[$];
  int d;
  always #5 clk = ~clk;
  ubf_core u_ubf_core (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .rx_pin_claim(rx_pin_claim),
    .ext_sync_clock(ext_sync_clock), .global_irq_enable(gie), .tx_done_irq_ack(txc_ack),
    .irq_tx_empty(irq_tx_empty), .irq_tx_done(irq_tx_done),
    .irq_rx_complete(irq_rx_complete));
  ubf_peer u_peer (.clk(clk), .serial_out_pin(serial_out_pin),
    .serial_in_pin(serial_in_pin), .ext_sync_clock(ext_sync_clock));
  // ****************
  // Tasks
  // ****************
  task automatic end_sim();
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input int b);
    repeat (500)
    begin
      apb(1'b0, OFS_STAT, 32'h0);
      if (rd[b] === 1'b1)
        return;
    end
  endtask
  task automatic wait_got(input int n);
    repeat (3000)
    begin
      if (u_peer.got_q.size() >= n)
        return;
      @(posedge clk);
    end
  endtask
  // Full frame as the peer packs it: data, even parity, stop
  function automatic int frame(input int v, input int n);
    int p = 0;
    for (int i = 0; i < n; i++)
      p ^= (v >> i) & 1;
    return (v & ((1 << n) - 1)) | (p << n) | (1 << (n + 1));
  endfunction
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, OFS_STAT, 32'h0);
    chk("status reset", rd, 32'h0000_0004);
    apb(1'b0, OFS_BAUD, 32'h0);
    chk("baud reset", rd, {16'h0000, BAUD_RST});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {rd[30:0], perr}, 32'h0000_0001);
    apb(1'b1, OFS_BAUD, 32'h0000_0003);
    apb(1'b1, OFS_CTRL, 32'h0000_02DF);
    gie <= 1'b1;
    @(posedge clk);
    chk("rx claim", rx_pin_claim, 1'b1);
    chk("empty irq", irq_tx_empty, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      d = $random(seed) & 8'hFF;
      exp_q.push_back(frame(d, 8));
      apb(1'b1, OFS_DATA, d);
    end
    apb(1'b0, OFS_STAT, 32'h0);
    chk("buffer full", {rd[2:1], irq_tx_empty}, 32'h0);
    wait_got(2);
    while (exp_q.size() > 0)
      chk("tx frame", u_peer.got_q.pop_front(), exp_q.pop_front());
    poll(1);
    chk("tx done", {rd[2:1], irq_tx_done}, 32'h7);
    @(posedge clk) txc_ack <= 1'b1;
    @(posedge clk) txc_ack <= 1'b0;
    apb(1'b0, OFS_STAT, 32'h0);
    chk("done ack", {rd[1], irq_tx_done}, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      d = $random(seed) & 8'hFF;
      if (i < 3)
        exp_q.push_back(d | (i == 0 ? 32'h400 : i == 2 ? 32'h200 : 32'h0));
      u_peer.send(d, i == 0, 0, 0);
    end
    while (exp_q.size() > 0)
    begin
      apb(1'b0, OFS_STAT, 32'h0);
      st = rd;
      apb(1'b0, OFS_DATA, 32'h0);
      chk("rx entry", {st[0], irq_rx_complete, st[5:3], rd[7:0]},
        exp_q.pop_front() | 32'h1800);
    end
    apb(1'b0, OFS_STAT, 32'h0);
    st = rd;
    apb(1'b0, OFS_DATA, 32'h0);
    chk("rx empty", {st[0], irq_rx_complete, rd[29:0]}, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0000_021F);
    u_peer.nbits = 5;
    u_peer.send(32'hFF, 0, 0, 0);
    poll(0);
    apb(1'b0, OFS_DATA, 32'h0);
    chk("short char", rd, 32'h0000_001F);
    u_peer.send($random(seed) & 8'h1F, 0, 1, 0);
    poll(0);
    chk("stop error", rd[3], 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0000_0217);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("flush", {rd[0], irq_rx_complete, rx_pin_claim}, 32'h0);
    d = $random(seed) & 8'h1F;
    apb(1'b1, OFS_DATA, d);
    apb(1'b1, OFS_CTRL, 32'h0000_0207);
    chk("oe held", serial_out_oe, 1'b1);
    wait_got(1);
    chk("last frame", u_peer.got_q.pop_front(), frame(d, 5));
    poll(1);
    repeat (2) @(posedge clk);
    chk("oe off", serial_out_oe, 1'b0);
    apb(1'b1, OFS_STAT, 32'h0000_0002);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("done w1c", {rd[1], irq_tx_done}, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0000_11C8);
    u_peer.nbits = 9;
    u_peer.par_en = 0;
    d = $random(seed) & 9'h1FF;
    u_peer.send(d, 0, 0, 1);
    poll(0);
    apb(1'b0, OFS_CTRL, 32'h0);
    st = rd;
    apb(1'b0, OFS_DATA, 32'h0);
    chk("sync ninth", {st[CB_RX9], rd[7:0]}, d);
    end_sim();
  end
endmodule
